// ---- shared/dofr_pkg.sv ----
// Package with register map, field layout, reset values and timing for the output router
package dofr_pkg;

  // Register word addresses on the plain register port
  localparam logic [3:0] ADDR_MODE      = 4'h0;  // Auxiliary output mode select
  localparam logic [3:0] ADDR_RELAY2    = 4'h1;  // Expansion relay a function select
  localparam logic [3:0] ADDR_BOARD     = 4'h2;  // Board relay function select
  localparam logic [3:0] ADDR_RELAY3    = 4'h3;  // Expansion relay b function select
  localparam logic [3:0] ADDR_DO1       = 4'h4;  // Digital output 1 function select
  localparam logic [3:0] ADDR_DO2       = 4'h5;  // Digital output 2 function select
  localparam logic [3:0] ADDR_SET_COUNT = 4'h6;  // Set count value
  localparam logic [3:0] ADDR_PULSE_HALF = 4'h7; // Pulse half period in clocks
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h8;  // Sticky output rise flags, read only
  localparam logic [3:0] ADDR_IRQ_CLR   = 4'h9;  // Write one to clear, write only
  localparam logic [3:0] ADDR_IRQ_EN    = 4'ha;  // Interrupt enable
  localparam logic [3:0] ADDR_OUT_STATE = 4'hb;  // Routed selector levels before terminal muxing, read only

  // Reset values of the selectors and controls
  localparam logic [15:0] RST_MODE      = 16'h0000;
  localparam logic [15:0] RST_RELAY2    = 16'h0000;
  localparam logic [15:0] RST_BOARD     = 16'h0002;
  localparam logic [15:0] RST_RELAY3    = 16'h0000;
  localparam logic [15:0] RST_DO1       = 16'h0001;
  localparam logic [15:0] RST_DO2       = 16'h0004;
  localparam logic [15:0] RST_SET_COUNT = 16'h0000;
  localparam logic [15:0] RST_PULSE_HALF = 16'h0000;

  // Mode register digits, decimal digits held as nibbles
  localparam int MODE_UNITS_LSB = 0;
  localparam int MODE_TENS_LSB  = 4;

  // Condition codes that a selector may hold
  localparam logic [15:0] CODE_NONE       = 16'h0000;
  localparam logic [15:0] CODE_RUNNING    = 16'h0001;
  localparam logic [15:0] CODE_FAULT      = 16'h0002;
  localparam logic [15:0] CODE_FREQ_LEVEL = 16'h0003;
  localparam logic [15:0] CODE_FREQ_REACH = 16'h0004;
  localparam logic [15:0] CODE_ZERO_RUN   = 16'h0005;
  localparam logic [15:0] CODE_MOTOR_OVL  = 16'h0006;
  localparam logic [15:0] CODE_DRIVE_OVL  = 16'h0007;
  localparam logic [15:0] CODE_COUNT_SET  = 16'h0008;
  localparam logic [15:0] CODE_PLC_CYCLE  = 16'h000b;
  localparam logic [15:0] CODE_ZERO_ANY   = 16'h0017;

  // Output slot order in five bit vectors
  localparam int OUT_RELAY2 = 0;
  localparam int OUT_BOARD  = 1;
  localparam int OUT_RELAY3 = 2;
  localparam int OUT_DO1    = 3;
  localparam int OUT_DO2    = 4;
  localparam int NUM_OUT    = 5;

  // Timing
  localparam longint CLK_HZ        = 20000000;  // System clock rate
  localparam longint PULSE_MAX_HZ  = 100000;    // Ceiling of the pulse terminal
  localparam longint PULSE_MIN_HALF_L = (CLK_HZ + 2 * PULSE_MAX_HZ - 1) / (2 * PULSE_MAX_HZ);
  localparam logic [15:0] PULSE_MIN_HALF = 16'(PULSE_MIN_HALF_L);  // Clocks per half period
  localparam longint PLC_PULSE_MS  = 250;       // Width of the sequencer cycle pulse
  localparam longint PLC_PULSE_CYC_L = CLK_HZ / 1000 * PLC_PULSE_MS;
  localparam logic [22:0] PLC_PULSE_CYC = 23'(PLC_PULSE_CYC_L);

  // Drive status conditions feeding the router
  typedef struct packed {
    logic running;         // Drive running, output frequency may be zero
    logic freq_zero;       // Output frequency is zero
    logic fault_stop;      // Fault has stopped the drive
    logic freq_level_first; // Frequency level detect first
    logic freq_reached;    // Frequency reached
    logic motor_ovl_warn;  // Motor load above forecast threshold
    logic drive_ovl_due;   // Drive overload trip due within 10 s
    logic plc_cycle_done;  // One cycle pulse at sequencer cycle end
  } dofr_status_t;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;   // Word address
    logic [15:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } dofr_req_t;

endpackage

// ---- src/dofr_router.sv ----
// Output function router: selectors, terminal multiplexing, pulse output and interrupts
//
// Behaviour
// - Mode units digit: pulse or relay a.
// - Mode tens digit: analog or relay b.
// - Pulse terminal frequency never above 100 kHz.
// - Five selectors each route one condition.
// - Digital output 2 selector resets to 4.
// - Code 0 keeps the output inactive.
// - Code 1 follows drive running.
// - Code 2 follows fault stop.
// - Code 5 running at zero frequency.
// - Code 6 follows motor overload forecast.
// - Code 7 active 10 s before trip.
// - Code 8 active when count reaches setting.
// - Code 11 gives 250 ms sequencer pulse.
// - Code 23 zero frequency or stopped.
`timescale 1ns/100ps
module dofr_router #(
  parameter logic [22:0] PLC_PULSE_CYC = dofr_pkg::PLC_PULSE_CYC  // Sequencer pulse width
) (
  input  wire logic                 clk_sys,              // System clock
  input  wire logic                 sys_rst,              // Synchronous reset, active high
  input  wire dofr_pkg::dofr_req_t  reg_req,              // Register request
  output logic [15:0]               reg_rdata,            // Read data, cycle after read
  input  wire dofr_pkg::dofr_status_t drv_status,         // Drive status conditions
  input  wire logic [15:0]          count_value,          // Internal counter value
  output logic                      pulse_out_terminal,   // Pulse terminal level
  output logic                      expansion_relay_a,    // Relay a coil
  output logic                      analog_out_second_en, // Second analog output enabled
  output logic                      expansion_relay_b,    // Relay b coil
  output logic                      board_relay,          // Board relay coil
  output logic                      digital_out1,         // Open collector output 1
  output logic                      digital_out2,         // Expansion digital output 2
  output logic                      irq                   // Level interrupt
);

  // Register file
  logic [15:0] mode_q;                  // Auxiliary output mode select
  logic [15:0] sel_q [dofr_pkg::NUM_OUT]; // Function selectors by output slot
  logic [15:0] set_count_q;             // Set count value
  logic [15:0] pulse_half_q;            // Requested pulse half period
  logic [4:0]  irq_stat_q;              // Sticky rise flags
  logic [4:0]  irq_en_q;                // Interrupt enables
  logic [15:0] rdata_q;                 // Registered read data

  // Routed outputs
  logic [4:0]  cond_d;                  // Condition chosen by each selector
  logic [4:0]  out_q;                   // Registered output conditions
  logic [4:0]  out_prev_q;              // Last cycle outputs for edge detect

  // Pulse and stretch state
  logic [22:0] plc_cnt_q;               // Sequencer pulse remaining
  logic        plc_pulse;               // Sequencer pulse active
  logic [15:0] half_eff;                // Half period after ceiling clamp
  logic [15:0] pcnt_q;                  // Pulse phase counter
  logic        pulse_wave_q;            // Pulse waveform
  logic        pulse_mode;              // Units digit selects pulse use
  logic        analog_mode;             // Tens digit selects analog use

  // Output flops
  logic        pulse_pin_q;
  logic        relay_a_q;
  logic        analog_en_q;
  logic        relay_b_q;
  logic        irq_q;

  // Map a selector code and the status onto one output level
  function automatic logic route_code(
    input logic [15:0]            code,
    input dofr_pkg::dofr_status_t st,
    input logic                   count_hit,
    input logic                   plc
  );
    logic r;
    r = 1'b0;
    unique case (code)
      dofr_pkg::CODE_NONE:       r = 1'b0;
      dofr_pkg::CODE_RUNNING:    r = st.running;
      dofr_pkg::CODE_FAULT:      r = st.fault_stop;
      dofr_pkg::CODE_FREQ_LEVEL: r = st.freq_level_first;
      dofr_pkg::CODE_FREQ_REACH: r = st.freq_reached;
      dofr_pkg::CODE_ZERO_RUN:   r = st.running & st.freq_zero;
      dofr_pkg::CODE_MOTOR_OVL:  r = st.motor_ovl_warn;
      dofr_pkg::CODE_DRIVE_OVL:  r = st.drive_ovl_due;
      dofr_pkg::CODE_COUNT_SET:  r = count_hit;
      dofr_pkg::CODE_PLC_CYCLE:  r = plc;
      dofr_pkg::CODE_ZERO_ANY:   r = st.freq_zero | ~st.running;
      default:                   r = 1'b0;
    endcase
    return r;
  endfunction

  // Register writes, selectors and controls
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mode_q                     <= dofr_pkg::RST_MODE;
      sel_q[dofr_pkg::OUT_RELAY2] <= dofr_pkg::RST_RELAY2;
      sel_q[dofr_pkg::OUT_BOARD]  <= dofr_pkg::RST_BOARD;
      sel_q[dofr_pkg::OUT_RELAY3] <= dofr_pkg::RST_RELAY3;
      sel_q[dofr_pkg::OUT_DO1]    <= dofr_pkg::RST_DO1;
      sel_q[dofr_pkg::OUT_DO2]    <= dofr_pkg::RST_DO2;
      set_count_q                <= dofr_pkg::RST_SET_COUNT;
      pulse_half_q               <= dofr_pkg::RST_PULSE_HALF;
      irq_en_q                   <= 5'h00;
    end
    else if (reg_req.wr)
    begin
      // Decode the write address
      case (reg_req.addr)
        dofr_pkg::ADDR_MODE:       mode_q <= reg_req.wdata;
        dofr_pkg::ADDR_RELAY2:     sel_q[dofr_pkg::OUT_RELAY2] <= reg_req.wdata;
        dofr_pkg::ADDR_BOARD:      sel_q[dofr_pkg::OUT_BOARD] <= reg_req.wdata;
        dofr_pkg::ADDR_RELAY3:     sel_q[dofr_pkg::OUT_RELAY3] <= reg_req.wdata;
        dofr_pkg::ADDR_DO1:        sel_q[dofr_pkg::OUT_DO1] <= reg_req.wdata;
        dofr_pkg::ADDR_DO2:        sel_q[dofr_pkg::OUT_DO2] <= reg_req.wdata;
        dofr_pkg::ADDR_SET_COUNT:  set_count_q <= reg_req.wdata;
        dofr_pkg::ADDR_PULSE_HALF: pulse_half_q <= reg_req.wdata;
        dofr_pkg::ADDR_IRQ_EN:     irq_en_q <= reg_req.wdata[4:0];
        default:                   ;  // Read only or unmapped: ignored
      endcase
    end
  end

  // Register reads, data stands one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdata_q <= 16'h0000;
    end
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        dofr_pkg::ADDR_MODE:       rdata_q <= mode_q;
        dofr_pkg::ADDR_RELAY2:     rdata_q <= sel_q[dofr_pkg::OUT_RELAY2];
        dofr_pkg::ADDR_BOARD:      rdata_q <= sel_q[dofr_pkg::OUT_BOARD];
        dofr_pkg::ADDR_RELAY3:     rdata_q <= sel_q[dofr_pkg::OUT_RELAY3];
        dofr_pkg::ADDR_DO1:        rdata_q <= sel_q[dofr_pkg::OUT_DO1];
        dofr_pkg::ADDR_DO2:        rdata_q <= sel_q[dofr_pkg::OUT_DO2];
        dofr_pkg::ADDR_SET_COUNT:  rdata_q <= set_count_q;
        dofr_pkg::ADDR_PULSE_HALF: rdata_q <= pulse_half_q;
        dofr_pkg::ADDR_IRQ_STAT:   rdata_q <= {11'h000, irq_stat_q};
        dofr_pkg::ADDR_IRQ_EN:     rdata_q <= {11'h000, irq_en_q};
        dofr_pkg::ADDR_OUT_STATE:  rdata_q <= {11'h000, out_q};
        default:                   rdata_q <= 16'h0000;  // Unmapped and write only
      endcase
    end
    else
    begin
      rdata_q <= 16'h0000;  // Data stands only in the cycle after the read
    end
  end

  // Stretch a sequencer cycle end into one fixed width pulse
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      plc_cnt_q <= 23'h000000;
    end
    else if (drv_status.plc_cycle_done)
    begin
      plc_cnt_q <= PLC_PULSE_CYC;
    end
    else if (plc_cnt_q != 23'h000000)
    begin
      plc_cnt_q <= plc_cnt_q - 23'h000001;
    end
  end

  assign plc_pulse = (plc_cnt_q != 23'h000000);

  // Selector routing for all five outputs
  always_comb
  begin
    for (int i = 0; i < dofr_pkg::NUM_OUT; i++)
    begin
      cond_d[i] = route_code(sel_q[i], drv_status, (count_value >= set_count_q),
                             plc_pulse);
    end
  end

  // Outputs follow their condition on the clock edge
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      out_q      <= 5'h00;
      out_prev_q <= 5'h00;
    end
    else
    begin
      out_q      <= cond_d;
      out_prev_q <= out_q;
    end
  end

  // Terminal use from the decimal digits of the mode register
  assign pulse_mode  = (mode_q[dofr_pkg::MODE_UNITS_LSB +: 4] == 4'h0);
  assign analog_mode = (mode_q[dofr_pkg::MODE_TENS_LSB +: 4] == 4'h0);

  // Clamp the half period so the rate stays under the ceiling
  assign half_eff = (pulse_half_q < dofr_pkg::PULSE_MIN_HALF) ?
                    dofr_pkg::PULSE_MIN_HALF : pulse_half_q;

  // Pulse generator, stopped while the period is zero or in switch use
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pcnt_q       <= 16'h0000;
      pulse_wave_q <= 1'b0;
    end
    else if (!pulse_mode || pulse_half_q == 16'h0000)
    begin
      pcnt_q       <= 16'h0000;
      pulse_wave_q <= 1'b0;
    end
    else if (pcnt_q >= half_eff - 16'h0001)
    begin
      pcnt_q       <= 16'h0000;
      pulse_wave_q <= ~pulse_wave_q;
    end
    else
    begin
      pcnt_q <= pcnt_q + 16'h0001;
    end
  end

  // Multiplexed terminals
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pulse_pin_q <= 1'b0;
      relay_a_q   <= 1'b0;
      analog_en_q <= 1'b0;
      relay_b_q   <= 1'b0;
    end
    else
    begin
      pulse_pin_q <= pulse_mode ? pulse_wave_q : 1'b0;
      relay_a_q   <= pulse_mode ? 1'b0 : out_q[dofr_pkg::OUT_RELAY2];
      analog_en_q <= analog_mode;
      relay_b_q   <= analog_mode ? 1'b0 : out_q[dofr_pkg::OUT_RELAY3];
    end
  end

  // Sticky rise flags, a new rise beats a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_stat_q <= 5'h00;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q &
                     ~((reg_req.wr && reg_req.addr == dofr_pkg::ADDR_IRQ_CLR) ?
                       reg_req.wdata[4:0] : 5'h00)) |
                    (out_q & ~out_prev_q);
    end
  end

  // Level interrupt from enabled flags
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  assign reg_rdata            = rdata_q;
  assign pulse_out_terminal   = pulse_pin_q;
  assign expansion_relay_a    = relay_a_q;
  assign analog_out_second_en = analog_en_q;
  assign expansion_relay_b    = relay_b_q;
  assign board_relay          = out_q[dofr_pkg::OUT_BOARD];
  assign digital_out1         = out_q[dofr_pkg::OUT_DO1];
  assign digital_out2         = out_q[dofr_pkg::OUT_DO2];
  assign irq                  = irq_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Spacing between pulse edges, counted in helper logic
  logic [15:0] gap_q;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || pulse_wave_q != $past(pulse_wave_q))
    begin
      gap_q <= 16'h0000;
    end
    else if (gap_q != 16'hffff)
    begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  sequence plc_start_s;
    drv_status.plc_cycle_done;
  endsequence

  sequence plc_hold_s;
    plc_pulse [*8];
  endsequence

  pulse_pin_mode_a: assert property (pulse_mode |=> pulse_pin_q == $past(pulse_wave_q))
    else $error("pulse terminal does not carry pulses in pulse use");
  relay_a_mode_a: assert property (!pulse_mode |=> relay_a_q == $past(out_q[0]))
    else $error("relay a does not follow its selector in switch use");
  analog_mode_a: assert property (
    !analog_mode |=> !analog_en_q && relay_b_q == $past(out_q[2]))
    else $error("second analog terminal not in switch use");
  // An edge is never followed by another edge on the next cycle
  pulse_ceiling_a: assert property (
    $changed(pulse_wave_q) |=> !$changed(pulse_wave_q))
    else $error("pulse edges on consecutive cycles");
  // Helper restarts one cycle late, so a full half period reads two short
  pulse_gap_a: assert property (
    $changed(pulse_wave_q) && $past(gap_q) != 16'h0000 |->
    $past(gap_q) >= dofr_pkg::PULSE_MIN_HALF - 16'h0002)
    else $error("pulse half period below the ceiling limit");
  do2_default_a: assert property ($fell(sys_rst) |-> sel_q[dofr_pkg::OUT_DO2] == 16'h0004)
    else $error("digital output 2 selector not at its reset code");
  code_none_a: assert property (sel_q[3] == 16'h0000 |=> !digital_out1)
    else $error("unused output is active");
  running_code_a: assert property (
    sel_q[3] == 16'h0001 |=> digital_out1 == $past(drv_status.running))
    else $error("running output does not follow running");
  fault_code_a: assert property (
    sel_q[1] == 16'h0002 |=> board_relay == $past(drv_status.fault_stop))
    else $error("fault output does not follow fault stop");
  zero_run_a: assert property (
    sel_q[4] == 16'h0005 && !drv_status.running |=> !digital_out2)
    else $error("zero speed output active while stopped");
  zero_any_a: assert property (
    sel_q[4] == 16'h0017 && !drv_status.running |=> digital_out2)
    else $error("zero speed output inactive while stopped");
  plc_pulse_a: assert property (plc_start_s |=> plc_hold_s)
    else $error("sequencer pulse ended early");
  bad_code_a: assert property (
    sel_q[3] == 16'h0009 || sel_q[3] > 16'h0017 |=> !digital_out1)
    else $error("unsupported code drives an output");
  irq_level_a: assert property (|(irq_stat_q & irq_en_q) |=> irq)
    else $error("interrupt not raised for enabled flag");

endmodule

// ---- tb/dofr_load_model.sv ----
// Load model on the pulse terminal: measures edge spacing and edge count
`timescale 1ns/100ps
module dofr_load_model (
  input  wire logic        clk_sys,     // System clock
  input  wire logic        clr,         // Restart the measurement
  input  wire logic        pulse_in,    // Pulse terminal level
  output logic [15:0]      min_gap_q,   // Shortest spacing between edges, clocks
  output logic [15:0]      edge_cnt_q   // Edges seen since restart
);
  logic        last_q;  // Level in the previous clock cycle
  logic [15:0] gap_q;   // Clocks since the last edge

  // Edge spacing watch; the first edge only starts a gap
  always_ff @(posedge clk_sys)
  begin
    last_q <= pulse_in;
    if (clr)
    begin
      gap_q      <= 16'h0000;
      min_gap_q  <= 16'hffff;
      edge_cnt_q <= 16'h0000;
    end
    else if (pulse_in !== last_q)
    begin
      edge_cnt_q <= edge_cnt_q + 16'h0001;
      gap_q      <= 16'h0001;
      // Keep the shortest half period seen
      if (edge_cnt_q != 16'h0000 && gap_q < min_gap_q)
        min_gap_q <= gap_q;
    end
    else if (gap_q != 16'hffff)
      gap_q <= gap_q + 16'h0001;
  end
endmodule

// ---- tb/dofr_router_bench.sv ----
// Testbench for the output router: register tasks and behaviour tests
`timescale 1ns/100ps
module dofr_router_bench;
  localparam logic [22:0] PLC_CYC = 23'h000014;  // Short sequencer pulse, 20 clocks

  logic                   clk_sys;      // System clock
  logic                   sys_rst;      // Synchronous reset
  dofr_pkg::dofr_req_t    reg_req;      // Register request
  logic [15:0]            reg_rdata;    // Read data
  dofr_pkg::dofr_status_t drv_status;   // Status conditions
  logic [15:0]            count_value;  // Counter value
  logic                   pulse_o;      // Pulse terminal
  logic                   rly_a;        // Relay a
  logic                   alog2_en;     // Second analog enabled
  logic                   rly_b;        // Relay b
  logic                   brd;          // Board relay
  logic                   do1;          // Digital output 1
  logic                   do2;          // Digital output 2
  logic                   irq;          // Interrupt
  logic                   meas_clr;     // Load model restart
  logic [15:0]            min_gap;      // Shortest pulse half period
  logic [15:0]            edge_cnt;     // Pulse edges
  int                     error_cnt;    // Mismatches
  int                     n_checks;     // Comparisons
  int                     cyc;          // Timeout counter
  int                     n;            // Scratch count
  logic                   exp_bit;      // Expected output level
  int codes[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 23, 40};  // Codes, 9 and 40 unsupported
  // Status patterns; every status bit but bit 0, the sequencer cycle end, answers with its own pattern signature
  logic [7:0] pats[5] = '{8'h00, 8'he0, 8'h94, 8'h38, 8'h4e};

  dofr_router #(.PLC_PULSE_CYC(PLC_CYC)) u_dofr_router (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .drv_status(drv_status), .count_value(count_value), .pulse_out_terminal(pulse_o),
    .expansion_relay_a(rly_a), .analog_out_second_en(alog2_en), .expansion_relay_b(rly_b),
    .board_relay(brd), .digital_out1(do1), .digital_out2(do2), .irq(irq));

  dofr_load_model u_dofr_load_model (
    .clk_sys(clk_sys), .clr(meas_clr), .pulse_in(pulse_o),
    .min_gap_q(min_gap), .edge_cnt_q(edge_cnt));

  // Clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // Expected output of a selector from status bits and count hit
  function automatic logic exp_out(input int code, input logic [7:0] s, input logic hit);
    case (code)
      1:       return s[7];
      2:       return s[5];
      3:       return s[4];
      4:       return s[3];
      5:       return s[7] & s[6];
      6:       return s[2];
      7:       return s[1];
      8:       return hit;
      23:      return s[6] | ~s[7];
      default: return 1'b0;
    endcase
  endfunction

  // One comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask

  // New status, then let both output paths settle
  task automatic set_st(input logic [7:0] v);
    @(posedge clk_sys);
    drv_status <= dofr_pkg::dofr_status_t'(v);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // Counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    reg_req = '0;
    drv_status = '0;
    count_value = 16'h000f;
    meas_clr = 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({15'h0, alog2_en}, 16'h0001, "analog use after reset");
    rd_chk(dofr_pkg::ADDR_MODE, 16'h0000, "mode reset");
    rd_chk(dofr_pkg::ADDR_RELAY2, 16'h0000, "relay a reset");
    rd_chk(dofr_pkg::ADDR_BOARD, 16'h0002, "board reset");
    rd_chk(dofr_pkg::ADDR_RELAY3, 16'h0000, "relay b reset");
    rd_chk(dofr_pkg::ADDR_DO1, 16'h0001, "do1 reset");
    rd_chk(dofr_pkg::ADDR_DO2, 16'h0004, "do2 reset");
    $display("test reset done");

    reg_wr(dofr_pkg::ADDR_IRQ_EN, 16'h0008);
    reg_wr(dofr_pkg::ADDR_IRQ_CLR, 16'h001f);
    set_st(8'h80);
    chk({15'h0, irq}, 16'h0001, "irq raised");
    rd_chk(dofr_pkg::ADDR_IRQ_STAT, 16'h0008, "irq status");
    reg_wr(dofr_pkg::ADDR_IRQ_EN, 16'h0000);
    set_st(8'h80);
    chk({15'h0, irq}, 16'h0000, "irq masked");
    reg_wr(dofr_pkg::ADDR_IRQ_STAT, 16'h0000);
    rd_chk(dofr_pkg::ADDR_IRQ_STAT, 16'h0008, "status read only");
    reg_wr(dofr_pkg::ADDR_IRQ_EN, 16'h0008);
    set_st(8'h80);
    chk({15'h0, irq}, 16'h0001, "irq unmasked");
    reg_wr(dofr_pkg::ADDR_IRQ_CLR, 16'h0008);
    set_st(8'h80);
    chk({15'h0, irq}, 16'h0000, "irq cleared");
    rd_chk(dofr_pkg::ADDR_IRQ_STAT, 16'h0000, "status cleared");
    rd_chk(dofr_pkg::ADDR_IRQ_CLR, 16'h0000, "clear write only");
    reg_wr(4'hc, 16'hffff);
    rd_chk(4'hc, 16'h0000, "unmapped");
    $display("test interrupt done");

    reg_wr(dofr_pkg::ADDR_SET_COUNT, 16'h0010);
    for (int i = 0; i < 12; i++)
    begin
      reg_wr(dofr_pkg::ADDR_DO1, 16'(codes[i]));
      for (int j = 0; j < 5; j++)
      begin
        set_st(pats[j]);
        exp_bit = exp_out(codes[i], pats[j], 1'b0);
        chk({15'h0, do1}, {15'h0, exp_bit}, "code");
      end
    end
    reg_wr(dofr_pkg::ADDR_DO1, dofr_pkg::CODE_COUNT_SET);
    count_value <= 16'h0010;
    set_st(8'h00);
    chk({15'h0, do1}, 16'h0001, "count reached");
    count_value <= 16'h000f;
    set_st(8'h00);
    chk({15'h0, do1}, 16'h0000, "count below");
    $display("test code table done");

    reg_wr(dofr_pkg::ADDR_DO1, dofr_pkg::CODE_PLC_CYCLE);
    @(posedge clk_sys);
    drv_status <= dofr_pkg::dofr_status_t'(8'h01);
    @(posedge clk_sys);
    drv_status <= dofr_pkg::dofr_status_t'(8'h00);
    n = 0;
    repeat (40)
    begin
      @(posedge clk_sys);
      #1;
      if (do1 === 1'b1)
        n++;
    end
    chk(16'(n), 16'(PLC_CYC), "sequencer pulse width");
    $display("test sequencer pulse done");

    reg_wr(dofr_pkg::ADDR_MODE, 16'h0011);
    reg_wr(dofr_pkg::ADDR_RELAY2, dofr_pkg::CODE_RUNNING);
    reg_wr(dofr_pkg::ADDR_RELAY3, dofr_pkg::CODE_ZERO_RUN);
    reg_wr(dofr_pkg::ADDR_DO1, dofr_pkg::CODE_FAULT);
    set_st(8'hc8);
    chk({11'h0, do2, do1, rly_b, brd, rly_a}, 16'h0015, "five outputs");
    chk({14'h0, alog2_en, pulse_o}, 16'h0000, "switch use");
    rd_chk(dofr_pkg::ADDR_OUT_STATE, 16'h0015, "output levels");
    reg_wr(dofr_pkg::ADDR_MODE, 16'h0000);
    set_st(8'hc8);
    chk({13'h0, alog2_en, rly_b, rly_a}, 16'h0004, "pulse and analog use");
    $display("test selectors done");

    reg_wr(dofr_pkg::ADDR_PULSE_HALF, 16'h000a);
    meas_clr <= 1'b0;
    repeat (1500) @(posedge clk_sys);
    #1;
    chk({15'h0, min_gap >= dofr_pkg::PULSE_MIN_HALF}, 16'h0001, "pulse ceiling");
    chk({15'h0, edge_cnt >= 16'h000a}, 16'h0001, "pulse running");
    $display("test pulse done");
    test_done();
  end
endmodule
